/* File: inc/qrs_pkg.sv */
// constants and types for the quasi-resonant skip, restart and overvoltage control
package qrs_pkg;

  // -------------------------------------------------------------------------
  // clock
  // -------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 40;

  // -------------------------------------------------------------------------
  // times in their own unit and derived cycle counts
  // -------------------------------------------------------------------------
  localparam int RING_TIMEOUT_NS = 8000;
  localparam int MIN_PERIOD_NS   = 8000;
  localparam int MAX_ON_NS       = 50000;
  localparam int OVP_DELAY_NS    = 1000;
  localparam int RECOVER_NS      = 100000;

  localparam int RING_TIMEOUT_CYC = (RING_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MIN_PERIOD_CYC   = (MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MAX_ON_CYC       = MAX_ON_NS / CLK_PERIOD_NS;
  localparam int OVP_DELAY_CYC    = (OVP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_CYC      = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // -------------------------------------------------------------------------
  // counter widths and terminal values
  // -------------------------------------------------------------------------
  localparam int TO_W  = 8;
  localparam int MP_W  = 8;
  localparam int ON_W  = 11;
  localparam int OV_W  = 5;
  localparam int RC_W  = 12;

  localparam logic [TO_W-1:0] TO_LAST = TO_W'(RING_TIMEOUT_CYC - 1);
  localparam logic [MP_W-1:0] MP_LAST = MP_W'(MIN_PERIOD_CYC - 1);
  localparam logic [ON_W-1:0] ON_LAST = ON_W'(MAX_ON_CYC - 1);
  localparam logic [OV_W-1:0] OV_LAST = OV_W'(OVP_DELAY_CYC - 1);
  localparam logic [RC_W-1:0] RC_LAST = RC_W'(RECOVER_CYC - 1);

  // -------------------------------------------------------------------------
  // operating modes
  // -------------------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_RUN     = 3'b001,
    MODE_FAULT   = 3'b010,
    MODE_RECOVER = 3'b100
  } qrs_mode_t;

  typedef struct packed {
    qrs_mode_t       mode;
    logic            drive;
    logic            pending;
    logic            demag_prev;
    logic            skip_prev;
    logic            soft_start;
    logic            floor_hold;
    logic [TO_W-1:0] to_cnt;
    logic            to_done;
    logic [MP_W-1:0] mp_cnt;
    logic            mp_done;
    logic [ON_W-1:0] on_cnt;
    logic [OV_W-1:0] ov_cnt;
    logic            ov_run;
    logic [RC_W-1:0] rc_cnt;
  } qrs_state_t;

  localparam qrs_state_t STATE_RESET = '{
    mode: MODE_RUN, drive: 1'b0, pending: 1'b0, demag_prev: 1'b0, skip_prev: 1'b0,
    soft_start: 1'b0, floor_hold: 1'b0, to_cnt: '0, to_done: 1'b0, mp_cnt: '0,
    mp_done: 1'b1, on_cnt: '0, ov_cnt: '0, ov_run: 1'b0, rc_cnt: '0};

endpackage

/* File: design/qrs_ctrl.sv */
// drive flip-flop, skip gating, ringing timeout, overvoltage latch and on-time guard
`timescale 1ns/10ps
//
// Summary of operation
// [RL1] a skip request resets the drive flip-flop and keeps pulses stopped while it lasts.
// [RL2] pulses resume only once the skip comparator (with its hysteresis) releases.
// [RL3] with no skip request the skip input does not touch the switching cycle.
// [RL4] every skip release launches a soft-start restart pulse.
// [RL5] while skipping, the peak setpoint is held at its floor instead of falling further.
// [RL6] a falling demagnetization crossing grants a new switch-on once the minimum period has run out.
// [RL7] each demagnetization crossing restarts the ringing timeout.
// [RL8] with no crossing for 8 us the timeout grants the restart instead.
// [RL9] a grant turns the drive on at once if skip is released, else waits for the release.
// [RL10] the plateau is sampled for overvoltage only after a delay from switch turn-off.
// [RL11] an overvoltage seen at the sampling pulse sets a persistent fault latch.
// [RL12] the fault latch blocks all pulses and requests the supply clamp.
// [RL13] the fault latch clears only when the supply falls below its collapse level.
// [RL14] the on-time ends when current sense reaches its maximum level.
// [RL15] a demagnetization grant before the minimum period from drive rise is ignored.
// [RL16] drive high longer than 50 us stops pulses and starts an auto-recovery wait.
// [RL17] the drive flip-flop is set by a qualified grant and reset by trip, skip or fault.
module qrs_ctrl
(
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic skip_request,
  input  wire logic demag_below,
  input  wire logic ovp_above,
  input  wire logic cs_trip,
  input  wire logic cs_max_trip,
  input  wire logic supply_low,
  output logic      gate_drive_output,
  output logic      supply_clamp_request,
  output logic      soft_start_restart,
  output logic      setpoint_floor_hold
);
  import qrs_pkg::*;

  qrs_state_t s;
  qrs_state_t next_s;

  logic demag_fall;
  logic grant;
  logic drive_set;
  logic drive_clr;
  logic ov_sample;
  logic on_limit;

  // -------------------------------------------------------------------------
  // next-state logic
  // -------------------------------------------------------------------------
  always_comb
  begin
    next_s     = s;
    demag_fall = demag_below & ~s.demag_prev;
    on_limit   = s.drive & (s.on_cnt == ON_LAST);
    ov_sample  = s.ov_run & (s.ov_cnt == OV_LAST);
    // early crossings are dropped, the timeout grant is a level
    grant      = (demag_fall & s.mp_done) | s.to_done;                   // [RL6] [RL8] [RL15]
    drive_clr  = cs_trip | cs_max_trip | skip_request | on_limit         // [RL14] [RL1] [RL16]
               | (s.mode != MODE_RUN);                                   // [RL12] [RL17]
    drive_set  = ~s.drive & (grant | s.pending) & ~drive_clr;           // [RL9] [RL2] [RL17]

    next_s.demag_prev = demag_below;
    next_s.skip_prev  = skip_request;
    next_s.soft_start = s.skip_prev & ~skip_request;                     // [RL4]
    next_s.floor_hold = skip_request;                                    // [RL5]

    // ringing timeout
    if (demag_fall)
    begin
      next_s.to_cnt  = '0;                                               // [RL7]
      next_s.to_done = 1'b0;
    end
    else if (!s.to_done)
    begin
      if (s.to_cnt == TO_LAST)
        next_s.to_done = 1'b1;                                           // [RL8]
      else
        next_s.to_cnt = s.to_cnt + 1'b1;
    end

    // minimum period timer
    if (!s.mp_done)
    begin
      if (s.mp_cnt == MP_LAST)
        next_s.mp_done = 1'b1;
      else
        next_s.mp_cnt = s.mp_cnt + 1'b1;
    end

    // grant held across a skip period
    if (grant & ~s.drive)
      next_s.pending = 1'b1;                                             // [RL9]

    // drive flip-flop
    if (drive_clr)
    begin
      next_s.drive = 1'b0;                                               // [RL17] [RL3]
    end
    else if (drive_set)
    begin
      next_s.drive   = 1'b1;
      next_s.pending = 1'b0;
      next_s.to_done = 1'b0;
      next_s.to_cnt  = '0;
      next_s.mp_cnt  = '0;                                               // [RL15]
      next_s.mp_done = 1'b0;
    end
    if (s.mode != MODE_RUN)
      next_s.pending = 1'b0;

    // on-time counter
    if (s.drive)
      next_s.on_cnt = s.on_cnt + 1'b1;
    else
      next_s.on_cnt = '0;

    // plateau sampling delay after turn-off
    if (s.drive & ~next_s.drive)
    begin
      next_s.ov_run = 1'b1;                                              // [RL10]
      next_s.ov_cnt = '0;
    end
    else if (ov_sample)
      next_s.ov_run = 1'b0;
    else if (s.ov_run)
      next_s.ov_cnt = s.ov_cnt + 1'b1;

    // mode sequencing
    unique case (s.mode)
      MODE_RUN:
      begin
        if (on_limit)
        begin
          next_s.mode   = MODE_RECOVER;                                  // [RL16]
          next_s.rc_cnt = '0;
        end
      end
      MODE_RECOVER:
      begin
        if (s.rc_cnt == RC_LAST)
        begin
          next_s.mode       = MODE_RUN;
          next_s.soft_start = 1'b1;
        end
        else
          next_s.rc_cnt = s.rc_cnt + 1'b1;
      end
      MODE_FAULT:
      begin
        if (supply_low)
          next_s.mode = MODE_RUN;                                        // [RL13]
      end
      default:
        next_s.mode = MODE_FAULT;
    endcase

    // a sample in the same cycle as supply collapse still latches
    if (ov_sample & ovp_above)
      next_s.mode = MODE_FAULT;                                          // [RL11]
  end

  // -------------------------------------------------------------------------
  // state register
  // -------------------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      s <= STATE_RESET;
    else
      s <= next_s;
  end

  assign gate_drive_output    = s.drive;
  assign supply_clamp_request = (s.mode == MODE_FAULT);                  // [RL12]
  assign soft_start_restart   = s.soft_start;
  assign setpoint_floor_hold  = s.floor_hold;

  // -------------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  skip_stops_drive_a: assert property (skip_request |=> !gate_drive_output) // [RL1]
    else $error("drive high after skip request");
  resume_after_release_a: assert property ($rose(gate_drive_output) |-> !$past(skip_request)) // [RL2]
    else $error("drive rose while skip was requested");
  skip_transparent_a: assert property (s.drive && s.mode == MODE_RUN && !skip_request // [RL3]
      && !cs_trip && !cs_max_trip && s.on_cnt != ON_LAST |=> gate_drive_output)
    else $error("drive dropped without a cause");
  soft_start_launch_a: assert property ($fell(skip_request) |=> soft_start_restart) // [RL4]
    else $error("no soft-start on skip release");
  floor_hold_a: assert property (skip_request |=> setpoint_floor_hold) // [RL5]
    else $error("setpoint floor not held while skipping");
  demag_grant_a: assert property (demag_fall && s.mp_done && !s.drive // [RL6]
      && !drive_clr |=> gate_drive_output)
    else $error("demag crossing did not restart drive");
  timeout_restart_a: assert property (demag_fall |=> s.to_cnt == '0 && !s.to_done) // [RL7]
    else $error("timeout not restarted by crossing");
  timeout_expire_a: assert property ($rose(s.to_done) |-> $past(s.to_cnt) == TO_LAST) // [RL8]
    else $error("timeout expired at wrong count");
  wait_release_a: assert property (s.pending && !s.drive && s.mode == MODE_RUN // [RL9]
      ##1 !drive_clr |=> gate_drive_output)
    else $error("pending grant not honoured after release");
  // the sample lands exactly 25 cycles after the last cycle with drive high, 24 after the drive fall
  sample_delay_a: assert property (ov_sample // [RL10]
      |-> $past(gate_drive_output, 25) && !$past(gate_drive_output, 24))
    else $error("plateau sampled before delay");
  // persistence is left to fault_hold_a, a supply collapse may follow at once
  fault_latch_a: assert property (ov_sample && ovp_above |=> supply_clamp_request) // [RL11]
    else $error("overvoltage sample did not latch fault");
  fault_blocks_a: assert property (supply_clamp_request |=> !gate_drive_output) // [RL12]
    else $error("drive active during fault");
  fault_hold_a: assert property (supply_clamp_request && !supply_low |=> supply_clamp_request) // [RL13]
    else $error("fault cleared without supply collapse");
  cs_max_end_a: assert property (cs_max_trip |=> !gate_drive_output) // [RL14]
    else $error("on-time passed current limit");
  min_period_a: assert property (demag_fall && !s.mp_done && !s.to_done && !s.pending // [RL15]
      |=> !$rose(gate_drive_output))
    else $error("early crossing restarted drive");
  max_on_a: assert property (on_limit |=> !gate_drive_output && s.mode != MODE_RUN) // [RL16]
    else $error("on-time limit did not stop pulses");
  drive_reset_a: assert property (gate_drive_output && (cs_trip || skip_request) // [RL17]
      |=> !gate_drive_output)
    else $error("drive not reset by trip or skip");

  burst_cycle_c: cover property ($fell(skip_request) ##[1:300] $rose(gate_drive_output));
  timeout_grant_c: cover property ($rose(s.to_done) ##1 $rose(gate_drive_output));
  fault_entry_c: cover property ($rose(supply_clamp_request));
  recovery_c: cover property (on_limit ##1 s.mode == MODE_RECOVER);

endmodule // qrs_ctrl

/* File: tb/qrs_stage_model.sv */
// behavioural flyback power stage with its current, demag and overvoltage comparators
`timescale 1ns/10ps
module qrs_stage_model
(
  input  wire logic        sys_clk,
  input  wire logic        gate,
  input  wire logic        ring_en,
  input  wire logic        ovp_hi,
  input  wire logic        cs_en,
  input  wire logic [15:0] on_len,
  input  wire logic [15:0] ring_dly,
  output logic             demag_below,
  output logic             cs_trip,
  output logic             ovp_above
);
  int on_cnt  = 0;
  int off_cnt = 0;
  initial
  begin
    demag_below = 1'b0;
    cs_trip     = 1'b0;
    ovp_above   = 1'b0;
  end
  // ramp while on, plateau then ringing (period 8 cycles) while off
  always @(posedge sys_clk)
  begin
    #1;
    if (gate)
    begin
      on_cnt++;
      off_cnt = 0;
    end
    else
    begin
      on_cnt = 0;
      off_cnt++;
    end
    cs_trip     = cs_en && on_cnt >= on_len;
    ovp_above   = ovp_hi && !gate && off_cnt < ring_dly;
    demag_below = ring_en && !gate && off_cnt >= ring_dly && off_cnt[2];
  end
endmodule // qrs_stage_model

/* File: tb/tb_top.sv */
// self-checking bench for the skip, restart and overvoltage control
`timescale 1ns/10ps
module tb_top;
  import qrs_pkg::*;
  logic        sys_clk = 0, rst = 1, skip_request = 0, cs_max_trip = 0, supply_low = 0;
  logic        ring_en = 0, ovp_hi = 0, cs_en = 0;
  logic [15:0] on_len = 16'h0014, ring_dly = 16'h0028;
  logic        demag_below, cs_trip, ovp_above;
  logic        gate_drive_output, supply_clamp_request, soft_start_restart, setpoint_floor_hold;
  logic [31:0] seed = 32'he935bd49;
  int          n_mismatch = 0, checks = 0, n, hi;
  int          exp_q[$];

  always #20 sys_clk = ~sys_clk;

  qrs_ctrl dut_u (.sys_clk(sys_clk), .rst(rst), .skip_request(skip_request),
    .demag_below(demag_below), .ovp_above(ovp_above), .cs_trip(cs_trip),
    .cs_max_trip(cs_max_trip), .supply_low(supply_low),
    .gate_drive_output(gate_drive_output), .supply_clamp_request(supply_clamp_request),
    .soft_start_restart(soft_start_restart), .setpoint_floor_hold(setpoint_floor_hold));

  qrs_stage_model stage_u (.sys_clk(sys_clk), .gate(gate_drive_output), .ring_en(ring_en),
    .ovp_hi(ovp_hi), .cs_en(cs_en), .on_len(on_len), .ring_dly(ring_dly),
    .demag_below(demag_below), .cs_trip(cs_trip), .ovp_above(ovp_above));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask

  // bounded wait for a drive level; cycles spent come back in w
  task automatic wait_gate(input logic lvl, input int lim, output int w);
    w = 0;
    while (gate_drive_output !== lvl)
    begin
      tick(1);
      w++;
      if (w > lim)
      begin
        n_mismatch++;
        $display("ERROR wait_gate expected %0b seen timeout", lvl);
        finish_test();
      end
    end
  endtask

  task automatic count_high(input int k);
    hi = 0;
    repeat (k)
    begin
      tick(1);
      hi += (gate_drive_output === 1'b1);
    end
  endtask

  initial
  begin
    tick(10);
    chk("reset_outs", {gate_drive_output, supply_clamp_request, soft_start_restart,
        setpoint_floor_hold}, 4'h0);
    rst = 0;
    // -----------------------------------------------------------------------
    // no ringing: timeout grants the first pulse
    // -----------------------------------------------------------------------
    wait_gate(1, 260, n);
    chk("timeout_grant", n >= 198 && n <= 203, 1);
    cs_max_trip = 1;
    tick(1);
    chk("max_trip_off", gate_drive_output, 0);
    cs_max_trip = 0;
    // -----------------------------------------------------------------------
    // early ringing is ignored until the minimum period runs out
    // -----------------------------------------------------------------------
    ring_en = 1;
    cs_en   = 1;
    wait_gate(1, 260, n);
    chk("min_period_rise", n >= 195 && n <= 212, 1);
    for (int i = 0; i < 3; i++)
    begin
      wait_gate(0, 1300, n);
      seed = xs(seed);
      on_len = 16'(10 + seed[5:0]);
      exp_q.push_back(int'(on_len));
      wait_gate(1, 260, n);
      wait_gate(0, 100, n);
      chk("on_time", n, exp_q.pop_front());
    end
    // -----------------------------------------------------------------------
    // overvoltage: short leakage ignored, long plateau latches
    // -----------------------------------------------------------------------
    ovp_hi   = 1;
    ring_dly = 16'h000a;
    wait_gate(1, 260, n);
    wait_gate(0, 100, n);
    wait_gate(1, 260, n);
    chk("leak_ignored", supply_clamp_request, 0);
    ring_dly = 16'h0028;
    wait_gate(0, 100, n);
    tick(30);
    chk("fault_latched", supply_clamp_request, 1);
    count_high(300);
    chk("fault_blocks", hi, 0);
    chk("fault_holds", supply_clamp_request, 1);
    supply_low = 1;
    tick(2);
    chk("fault_cleared", supply_clamp_request, 0);
    supply_low = 0;
    ovp_hi     = 0;
    ring_en    = 0;
    // -----------------------------------------------------------------------
    // skip burst with a timeout grant pending
    // -----------------------------------------------------------------------
    wait_gate(1, 300, n);
    skip_request = 1;
    tick(1);
    chk("skip_off", {gate_drive_output, setpoint_floor_hold}, 2'b01);
    count_high(300);
    chk("skip_blocks", hi, 0);
    cs_en        = 0;
    skip_request = 0;
    tick(1);
    chk("skip_release", {soft_start_restart, gate_drive_output, setpoint_floor_hold},
        3'b110);
    // -----------------------------------------------------------------------
    // on-time guard and recovery wait
    // -----------------------------------------------------------------------
    wait_gate(0, 1300, n);
    chk("max_on", n, MAX_ON_CYC);
    wait_gate(1, 2800, n);
    chk("recovery", n >= RECOVER_CYC, 1);
    finish_test();
  end
endmodule // tb_top
